// File: pll_config_word_decode.sv
// Decoder of the non-volatile clock default configuration word.
// Assumes the word from configuration memory is valid while nrst is low
// and at its release; the register port is synchronous to clock.
`timescale 1ns/1ps
module pll_config_word_decode #(
  parameter bit HAS_USB = 1'b1
)(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] cfgMemWord,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  output clock_cfg_pkg::pll_settings_type pllSettings,
  output logic settingsValid
);

  // ***********************************************************
  // Decode functions
  // ***********************************************************
  // Code 7 breaks the power-of-two pattern, so it is decoded apart
  function automatic logic [8:0] decodeOutDiv(input logic [2:0] sel);
    if (sel == 3'h7)
      return 9'h100;
    return 9'(9'h001 << sel);
  endfunction

  // The two top codes jump to 10 and 12; lower codes are code plus one
  function automatic logic [3:0] decodeUsbDiv(input logic [2:0] sel);
    case (sel)
      3'h6: return 4'hA;
      3'h7: return 4'hC;
      default: return 4'(sel) + 4'h1;
    endcase
  endfunction

  // Code 7 skips 22 and 23 and lands on 24
  function automatic logic [4:0] decodeMul(input logic [2:0] sel);
    if (sel == 3'h7)
      return 5'h18;
    return 5'(sel) + 5'h0F;
  endfunction

  // ***********************************************************
  // Capture of the configuration word
  // ***********************************************************
  logic captured_ff;
  logic [31:0] word_ff;
  logic reservedBad_ff;
  logic [31:0] usbMask;
  logic [31:0] maskedWord;

  // Variants without USB read the USB fields as their erased value
  assign usbMask = HAS_USB ? 32'h0000_0000 : clock_cfg_pkg::USB_FIELD_MASK;
  assign maskedWord = cfgMemWord | usbMask;

  // Capture on the first edge after release; a reset constant cannot hold a port value
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      captured_ff <= 1'b0;
      word_ff <= clock_cfg_pkg::CFG_RESET;
    end
    else if (!captured_ff)
    begin
      captured_ff <= 1'b1;
      word_ff <= maskedWord;
    end
  end

  // Flag a word whose reserved bits were not programmed to one
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reservedBad_ff <= 1'b0;
    else if (!captured_ff)
      reservedBad_ff <= (cfgMemWord & clock_cfg_pkg::RESERVED_MASK)
        != clock_cfg_pkg::RESERVED_MASK;
  end

  // ***********************************************************
  // Decoded settings toward the PLL
  // ***********************************************************
  clock_cfg_pkg::pll_settings_type nxt_settings;

  always_comb
  begin
    nxt_settings.outDivisor = decodeOutDiv(word_ff[clock_cfg_pkg::ODIV_LSB +: 3]);
    nxt_settings.multiplier = decodeMul(word_ff[clock_cfg_pkg::MUL_LSB +: 3]);
    nxt_settings.usbPllDisable = word_ff[clock_cfg_pkg::UPLL_DIS_BIT];
    nxt_settings.usbInputDivider = decodeUsbDiv(word_ff[clock_cfg_pkg::UIDIV_LSB +: 3]);
    nxt_settings.inputDividerSel = word_ff[clock_cfg_pkg::IDIV_LSB +: 3];
  end

  // Settings register; only changes in the cycle after capture
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pllSettings <= '{9'h100, 5'h18, 1'b1, 4'hC, 3'h7};
      settingsValid <= 1'b0;
    end
    else
    begin
      pllSettings <= nxt_settings;
      settingsValid <= captured_ff;
    end
  end

  // ***********************************************************
  // Register read port
  // ***********************************************************
  // Writes are ignored: the word comes from programmed memory only
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      regRdData <= 32'h0000_0000;
    else if (regRead)
    begin
      case (regAddr)
        clock_cfg_pkg::CFG_WORD_ADDR: regRdData <= word_ff;
        clock_cfg_pkg::STATUS_ADDR: regRdData <= {30'h0, reservedBad_ff, captured_ff};
        default: regRdData <= 32'h0000_0000;
      endcase
    end
    else
      regRdData <= 32'h0000_0000;
  end

  // ***********************************************************
  // Assertions
  // ***********************************************************
  hold_stable_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid |=> $stable(pllSettings))
    else $error("PLL settings changed after capture");
  out_div_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h7 |-> pllSettings.outDivisor == 9'h100)
    else $error("Divisor code 7 not 256");
  out_div_pow_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] != 3'h7 |->
    pllSettings.outDivisor == 9'(9'h001 << word_ff[18:16]))
    else $error("Divisor not a power of two");
  usb_dis_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid |-> pllSettings.usbPllDisable == word_ff[15])
    else $error("USB PLL disable mismatch");
  usb_div_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h6 |-> pllSettings.usbInputDivider == 4'hA)
    else $error("USB divider code 6 not 10");
  mul_code_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h0 |-> pllSettings.multiplier == 5'h0F)
    else $error("Multiplier code 0 not 15");
  read_back_a: assert property (@(posedge clock) disable iff (!nrst)
    regRead && regAddr == 4'h0 |=> regRdData == $past(word_ff))
    else $error("Word read back wrong");
  no_write_a: assert property (@(posedge clock) disable iff (!nrst)
    captured_ff && regWrite |=> $stable(word_ff))
    else $error("Write altered config word");
  usb_absent_a: assert property (@(posedge clock) disable iff (!nrst)
    !HAS_USB && captured_ff |-> (word_ff & 32'h0000_8700) == 32'h0000_8700)
    else $error("USB fields present without USB");
  valid_after_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(captured_ff) |=> settingsValid)
    else $error("Settings not valid after capture");

  // ***********************************************************
  // Per-code decode checks, one literal per code
  // ***********************************************************
  // Output divisor codes 0 to 6; literals rather than a shift,
  // so a slip in the decode function cannot hide in the check
  div_code0_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h0 |-> pllSettings.outDivisor == 9'h001)
    else $error("Divisor code 0 not 1");
  div_code1_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h1 |-> pllSettings.outDivisor == 9'h002)
    else $error("Divisor code 1 not 2");
  div_code2_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h2 |-> pllSettings.outDivisor == 9'h004)
    else $error("Divisor code 2 not 4");
  div_code3_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h3 |-> pllSettings.outDivisor == 9'h008)
    else $error("Divisor code 3 not 8");
  div_code4_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h4 |-> pllSettings.outDivisor == 9'h010)
    else $error("Divisor code 4 not 16");
  div_code5_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h5 |-> pllSettings.outDivisor == 9'h020)
    else $error("Divisor code 5 not 32");
  div_code6_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[18:16] == 3'h6 |-> pllSettings.outDivisor == 9'h040)
    else $error("Divisor code 6 not 64");

  // USB input divider codes other than 6; the no-USB copy only
  // ever reaches code 7 here
  usb_code0_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h0 |-> pllSettings.usbInputDivider == 4'h1)
    else $error("USB divider code 0 not 1");
  usb_code1_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h1 |-> pllSettings.usbInputDivider == 4'h2)
    else $error("USB divider code 1 not 2");
  usb_code2_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h2 |-> pllSettings.usbInputDivider == 4'h3)
    else $error("USB divider code 2 not 3");
  usb_code3_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h3 |-> pllSettings.usbInputDivider == 4'h4)
    else $error("USB divider code 3 not 4");
  usb_code4_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h4 |-> pllSettings.usbInputDivider == 4'h5)
    else $error("USB divider code 4 not 5");
  usb_code5_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h5 |-> pllSettings.usbInputDivider == 4'h6)
    else $error("USB divider code 5 not 6");
  usb_code7_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[10:8] == 3'h7 |-> pllSettings.usbInputDivider == 4'hC)
    else $error("USB divider code 7 not 12");

  // Multiplier codes 1 to 7; code 7 is the irregular one
  // and the likeliest to be decoded wrong
  mul_code1_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h1 |-> pllSettings.multiplier == 5'h10)
    else $error("Multiplier code 1 not 16");
  mul_code2_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h2 |-> pllSettings.multiplier == 5'h11)
    else $error("Multiplier code 2 not 17");
  mul_code3_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h3 |-> pllSettings.multiplier == 5'h12)
    else $error("Multiplier code 3 not 18");
  mul_code4_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h4 |-> pllSettings.multiplier == 5'h13)
    else $error("Multiplier code 4 not 19");
  mul_code5_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h5 |-> pllSettings.multiplier == 5'h14)
    else $error("Multiplier code 5 not 20");
  mul_code6_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h6 |-> pllSettings.multiplier == 5'h15)
    else $error("Multiplier code 6 not 21");
  mul_code7_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid && word_ff[6:4] == 3'h7 |-> pllSettings.multiplier == 5'h18)
    else $error("Multiplier code 7 not 24");

  // ***********************************************************
  // Read port and capture bookkeeping
  // ***********************************************************
  // Read data only stands in the cycle after a strobe
  read_idle_a: assert property (@(posedge clock) disable iff (!nrst)
    !regRead |=> regRdData == 32'h0000_0000)
    else $error("Read data not zero when idle");
  // Unmapped indices must not leak the word
  read_unmapped_a: assert property (@(posedge clock) disable iff (!nrst)
    regRead && regAddr > 4'h1 |=> regRdData == 32'h0000_0000)
    else $error("Unmapped index read not zero");
  // Status shows only the two flags
  read_status_a: assert property (@(posedge clock) disable iff (!nrst)
    regRead && regAddr == 4'h1 |=> regRdData[31:2] == 30'h0
    && regRdData[0] == $past(captured_ff))
    else $error("Status read wrong");
  // Reserved flag judges the word seen at capture
  reserved_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(captured_ff) |-> reservedBad_ff
    == (($past(cfgMemWord) & 32'hFFF8_7888) != 32'hFFF8_7888))
    else $error("Reserved flag wrong");
  // Capture is a one-shot until the next reset
  capture_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
    captured_ff |=> captured_ff)
    else $error("Capture flag fell");
  // The held word may only change at capture
  word_held_a: assert property (@(posedge clock) disable iff (!nrst)
    captured_ff |=> $stable(word_ff))
    else $error("Held word changed");
  // Valid never drops back before a reset
  valid_sticky_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid |=> settingsValid)
    else $error("Settings valid fell");
  // Input divider field has no known encoding, so it passes raw
  idiv_raw_a: assert property (@(posedge clock) disable iff (!nrst)
    settingsValid |-> pllSettings.inputDividerSel == word_ff[2:0])
    else $error("Input divider not passed raw");
  // With USB present the enable bit is taken as programmed
  usb_taken_a: assert property (@(posedge clock) disable iff (!nrst)
    HAS_USB && $rose(captured_ff) |-> word_ff[15] == $past(cfgMemWord[15]))
    else $error("USB enable bit not captured");

  capture_c: cover property (@(posedge clock) disable iff (!nrst) $rose(settingsValid));
  div256_c: cover property (@(posedge clock) disable iff (!nrst)
    settingsValid && pllSettings.outDivisor == 9'h100);
  usb_on_c: cover property (@(posedge clock) disable iff (!nrst)
    settingsValid && !pllSettings.usbPllDisable);
  bad_res_c: cover property (@(posedge clock) disable iff (!nrst) reservedBad_ff);
  status_rd_c: cover property (@(posedge clock) disable iff (!nrst)
    regRead && regAddr == 4'h1);

endmodule

// File: clock_cfg_pkg.sv
// Constants and carrier types for the clock default configuration word decoder.
// Assumes a single 20 MHz clock domain and an active-low asynchronous reset.
package clock_cfg_pkg;

  // ***********************************************************
  // Register map and field layout
  // ***********************************************************
  localparam logic [3:0] CFG_WORD_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h1;
  localparam int ODIV_LSB = 16;
  localparam int UPLL_DIS_BIT = 15;
  localparam int UIDIV_LSB = 8;
  localparam int MUL_LSB = 4;
  localparam int IDIV_LSB = 0;
  localparam logic [31:0] RESERVED_MASK = 32'hFFF8_7888;
  localparam logic [31:0] CFG_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] USB_FIELD_MASK = 32'h0000_8700;

  // ***********************************************************
  // Decoded settings handed to the PLL logic
  // ***********************************************************
  typedef struct packed {
    logic [8:0] outDivisor;
    logic [4:0] multiplier;
    logic usbPllDisable;
    logic [3:0] usbInputDivider;
    logic [2:0] inputDividerSel;
  } pll_settings_type;

endpackage

// File: pll_config_word_decode_bench.sv
// Self-checking bench for the clock default configuration word decoder.
// Assumes clock_cfg_pkg is compiled first; the bench drives every port.
`timescale 1ns/1ps
module pll_config_word_decode_bench;
  logic clock;
  logic nrst;
  logic [31:0] cfgMemWord;
  logic [3:0] regAddr;
  logic [31:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [31:0] rdA;
  logic [31:0] rdB;
  clock_cfg_pkg::pll_settings_type setA;
  clock_cfg_pkg::pll_settings_type setB;
  clock_cfg_pkg::pll_settings_type e;
  clock_cfg_pkg::pll_settings_type eB;
  logic validA;
  logic [31:0] w;
  int err_total;
  int checked;
  int odiv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
  int mul[8] = '{15, 16, 17, 18, 19, 20, 21, 24};
  int udiv[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  // ************************************
  // Devices under test
  // ************************************
  // Second copy lacks the USB controller
  pll_config_word_decode #(.HAS_USB(1'b1)) pll_config_word_decode_inst (.clock(clock),
    .nrst(nrst), .cfgMemWord(cfgMemWord), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(rdA), .pllSettings(setA),
    .settingsValid(validA));
  pll_config_word_decode #(.HAS_USB(1'b0)) pll_config_word_decode_inst_nousb (.clock(clock),
    .nrst(nrst), .cfgMemWord(cfgMemWord), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(rdB), .pllSettings(setB),
    .settingsValid());
  // ************************************
  // Tasks
  // ************************************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task chk_set(input clock_cfg_pkg::pll_settings_type got,
               input clock_cfg_pkg::pll_settings_type exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: settings %h expected %h", $time, got, exp);
    end
  endtask
  // Reset with a new memory word; bounded wait for the capture
  task rst(input logic [31:0] word, input int len);
    @(posedge clock);
    nrst <= 1'b0;
    cfgMemWord <= word;
    repeat (len) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 8 && validA !== 1'b1; i++) @(posedge clock);
    if (validA !== 1'b1)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // Read data stands in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(negedge clock);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  // ************************************
  // Clock and sequence
  // ************************************
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    nrst = 1'b0;
    cfgMemWord = 32'hFFFF_FFFF;
    regAddr = 4'h0;
    regWrData = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    err_total = 0;
    checked = 0;
    // Reserved bit cleared must show in status; unmapped index reads zero
    rst(32'h7FFF_FFFF, 20);
    rd(clock_cfg_pkg::STATUS_ADDR);
    chk_word(rdA, 32'h0000_0003);
    rd(4'hF);
    chk_word(rdA, 32'h0000_0000);
    $display("test reserved done");
    // Every code of every field, same code in all fields at once
    for (int c = 0; c < 8; c++)
    begin
      w = clock_cfg_pkg::RESERVED_MASK | (32'(c) << 16) | (32'(c & 1) << 15)
        | (32'(c) << 8) | (32'(c) << 4) | 32'(c);
      rst(w, 2);
      @(negedge clock);
      e = '{9'(odiv[c]), 5'(mul[c]), 1'(c & 1), 4'(udiv[c]), 3'(c)};
      eB = '{9'(odiv[c]), 5'(mul[c]), 1'b1, 4'hC, 3'(c)};
      chk_set(setA, e);
      chk_set(setB, eB);
      // Memory changes and a write try must not disturb the held word
      @(posedge clock);
      cfgMemWord <= ~w;
      wr(clock_cfg_pkg::CFG_WORD_ADDR, ~w);
      rd(clock_cfg_pkg::CFG_WORD_ADDR);
      chk_word(rdA, w);
      chk_word(rdB, w | clock_cfg_pkg::USB_FIELD_MASK);
      chk_set(setA, e);
      rd(clock_cfg_pkg::STATUS_ADDR);
      chk_word(rdA, 32'h0000_0001);
      @(negedge clock);
      chk_word(rdA, 32'h0000_0000);
      $display("test code %0d done", c);
    end
    tally_and_finish();
  end
endmodule
